/* File: verilog/siods_regs.sv */
// Host register ports, termination control and latched events of the serial I/O block.
`default_nettype none
module siods_regs #(
    parameter int P_UART_TMO_CYC = siods_pkg::UART_TMO_CYC
) (
    // Clock and reset.
    input  wire  logic                                 i_ref_clk,
    input  wire  logic                                 i_reset,
    // Host register access.
    input  wire  logic                                 i_wr,
    input  wire  logic                                 i_rd,
    input  wire  logic [7:0]                           i_addr,
    input  wire  logic [31:0]                          i_wdata,
    output var   logic [31:0]                          o_rdata,
    output var   logic                                 o_rvalid,
    // Interrupt configuration and request.
    input  wire  logic [15:0]                          i_int_enable,
    input  wire  logic                                 i_master_int_en,
    output var   logic                                 o_int_status,
    output var   logic                                 o_inta_n,
    output var   logic                                 o_inta_oe_n,
    // Index interfaces.
    input  wire  siods_pkg::siods_idx_in_t [1:0]       i_idx,
    output var   logic [1:0]                           o_idx_tx_load,
    output var   logic [1:0][8:0]                      o_idx_tx_word,
    output var   logic [1:0][8:0]                      o_idx_auto_a,
    output var   logic [1:0][8:0]                      o_idx_auto_b,
    // UART FIFOs and read-acknowledge data.
    input  wire  siods_pkg::siods_uart_in_t [1:0]      i_uart,
    output var   logic [1:0]                           o_uart_push,
    output var   logic [1:0]                           o_uart_pop,
    output var   logic [31:0]                          o_uart_wdata,
    output var   logic [1:0][31:0]                     o_read_ack_data,
    // Response FIFOs.
    input  wire  siods_pkg::siods_resp_in_t [1:0]      i_resp,
    output var   logic [1:0]                           o_resp_pop,
    // Line terminators.
    output var   logic [31:0]                          o_term_en
);
    localparam int EVW = siods_pkg::EVENT_W;

    logic [1:0][8:0]   auto_a_q;
    logic [1:0][8:0]   auto_b_q;
    logic [1:0][11:0]  rx_hold_q;
    logic [1:0][31:0]  rdack_q;
    logic [13:0]       term_q;
    logic [EVW-1:0]    events_q;
    logic [EVW-1:0]    ev_set;
    logic [EVW-1:0]    ev_clr;
    logic [31:0]       term_d;
    logic [1:0]        wr_imm;
    logic [1:0]        wr_auto_a;
    logic [1:0]        wr_auto_b;
    logic [1:0]        wr_uart;
    logic [1:0]        wr_rdack;
    logic [1:0]        rd_uart;
    logic [1:0]        rd_resp;
    logic [31:0]       rdata_d;

    // Write decode.
    always_comb begin
        wr_imm    = '0;
        wr_auto_a = '0;
        wr_auto_b = '0;
        wr_uart   = '0;
        wr_rdack  = '0;
        if (i_addr == siods_pkg::OFS_IDX1_IMM) begin
            wr_imm[0] = i_wr;
        end else if (i_addr == siods_pkg::OFS_IDX2_IMM) begin
            wr_imm[1] = i_wr;
        end else if (i_addr == siods_pkg::OFS_IDX1_AUTO_A) begin
            wr_auto_a[0] = i_wr;
        end else if (i_addr == siods_pkg::OFS_IDX2_AUTO_A) begin
            wr_auto_a[1] = i_wr;
        end else if (i_addr == siods_pkg::OFS_IDX1_AUTO_B) begin
            wr_auto_b[0] = i_wr;
        end else if (i_addr == siods_pkg::OFS_IDX2_AUTO_B) begin
            wr_auto_b[1] = i_wr;
        end else if (i_addr == siods_pkg::OFS_UART1_FIFO) begin
            wr_uart[0] = i_wr;
        end else if (i_addr == siods_pkg::OFS_UART2_FIFO) begin
            wr_uart[1] = i_wr;
        end else if (i_addr == siods_pkg::OFS_UART1_RDACK) begin
            wr_rdack[0] = i_wr;
        end else if (i_addr == siods_pkg::OFS_UART2_RDACK) begin
            wr_rdack[1] = i_wr;
        end
    end

    // Read decode and data selection.
    always_comb begin
        rdata_d = '0;
        rd_uart = '0;
        rd_resp = '0;
        if (i_addr == siods_pkg::OFS_IDX1_IMM) begin
            rdata_d = {20'h00000, rx_hold_q[0]};
        end else if (i_addr == siods_pkg::OFS_IDX2_IMM) begin
            rdata_d = {20'h00000, rx_hold_q[1]};
        end else if (i_addr == siods_pkg::OFS_IDX1_AUTO_A) begin
            rdata_d = {23'h000000, auto_a_q[0]};
        end else if (i_addr == siods_pkg::OFS_IDX2_AUTO_A) begin
            rdata_d = {23'h000000, auto_a_q[1]};
        end else if (i_addr == siods_pkg::OFS_IDX1_AUTO_B) begin
            rdata_d = {23'h000000, auto_b_q[0]};
        end else if (i_addr == siods_pkg::OFS_IDX2_AUTO_B) begin
            rdata_d = {23'h000000, auto_b_q[1]};
        end else if (i_addr == siods_pkg::OFS_UART1_FIFO) begin
            rdata_d = i_uart[0].rx_data;
            rd_uart[0] = i_rd & (~i_uart[0].controller | i_uart[0].loop_test);
        end else if (i_addr == siods_pkg::OFS_UART2_FIFO) begin
            rdata_d = i_uart[1].rx_data;
            rd_uart[1] = i_rd & (~i_uart[1].controller | i_uart[1].loop_test);
        end else if (i_addr == siods_pkg::OFS_TERM) begin
            rdata_d = {18'h00000, term_q};
        end else if (i_addr == siods_pkg::OFS_EVENTS) begin
            rdata_d = {16'h0000, events_q};
        end else if (i_addr == siods_pkg::OFS_UART1_RDACK) begin
            rdata_d = rdack_q[0];
        end else if (i_addr == siods_pkg::OFS_UART2_RDACK) begin
            rdata_d = rdack_q[1];
        end else if (i_addr == siods_pkg::OFS_RESP1_FIFO) begin
            rd_resp[0] = i_rd & i_resp[0].valid;
            rdata_d = i_resp[0].valid ? {24'h000000, i_resp[0].data} : 32'h0000_0000;
        end else if (i_addr == siods_pkg::OFS_RESP2_FIFO) begin
            rd_resp[1] = i_rd & i_resp[1].valid;
            rdata_d = i_resp[1].valid ? {24'h000000, i_resp[1].data} : 32'h0000_0000;
        end
    end

    // Read return, one cycle after the strobe.
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_rdata  <= siods_pkg::RST_WORD;
            o_rvalid <= 1'b0;
        end else begin
            o_rvalid <= i_rd;
            o_rdata  <= i_rd ? rdata_d : siods_pkg::RST_WORD;
        end
    end

    // FIFO strobes toward the UARTs and response FIFOs.
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_uart_push  <= '0;
            o_uart_pop   <= '0;
            o_resp_pop   <= '0;
            o_uart_wdata <= siods_pkg::RST_WORD;
        end else begin
            for (int c = 0; c < 2; c++) begin
                o_uart_push[c] <= wr_uart[c] & (i_uart[c].controller | i_uart[c].loop_test);
            end
            o_uart_pop   <= rd_uart;
            o_resp_pop   <= rd_resp;
            o_uart_wdata <= i_wdata;
        end
    end

    // Register storage.
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            auto_a_q <= '0;
            auto_b_q <= '0;
            rdack_q  <= '0;
            term_q   <= siods_pkg::RST_TERM;
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (wr_auto_a[c]) begin
                    auto_a_q[c] <= i_wdata[8:0];
                end
                if (wr_auto_b[c]) begin
                    auto_b_q[c] <= i_wdata[8:0];
                end
                if (wr_rdack[c]) begin
                    rdack_q[c] <= i_wdata;
                end
            end
            if (i_wr && i_addr == siods_pkg::OFS_TERM) begin
                term_q <= i_wdata[13:0];
            end
        end
    end

    assign o_idx_auto_a    = auto_a_q;
    assign o_idx_auto_b    = auto_b_q;
    assign o_read_ack_data = rdack_q;

    // Per index interface: transmit load, receive hold and timers.
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_chan
            logic [siods_pkg::TMO_W-1:0] idx_cnt_q;
            logic                        idx_wait_q;
            logic [15:0]                 uart_cnt_q;
            logic                        uart_wait_q;
            logic                        idx_tmo;
            logic                        uart_tmo;

            assign idx_tmo  = idx_wait_q && !i_idx[g].resp_seen
                              && (idx_cnt_q + 16'h0001 >= i_idx[g].timeout_cyc);
            assign uart_tmo = uart_wait_q && !i_uart[g].resp_seen
                              && (uart_cnt_q + 16'h0001 >= 16'(P_UART_TMO_CYC));

            always_ff @(posedge i_ref_clk) begin
                if (i_reset) begin
                    o_idx_tx_load[g] <= 1'b0;
                    o_idx_tx_word[g] <= '0;
                end else begin
                    o_idx_tx_load[g] <= wr_imm[g] & i_idx[g].enable & i_idx[g].tx_first;
                    if (wr_imm[g]) begin
                        o_idx_tx_word[g] <= i_wdata[8:0];
                    end
                end
            end

            always_ff @(posedge i_ref_clk) begin
                if (i_reset) begin
                    rx_hold_q[g] <= '0;
                end else if (i_idx[g].rx_done) begin
                    rx_hold_q[g] <= i_idx[g].resp12
                                    ? {i_idx[g].status, i_idx[g].rx_word}
                                    : {3'h0, i_idx[g].rx_word};
                end
            end

            always_ff @(posedge i_ref_clk) begin
                if (i_reset) begin
                    idx_wait_q <= 1'b0;
                    idx_cnt_q  <= '0;
                end else if (i_idx[g].sent) begin
                    idx_wait_q <= 1'b1;
                    idx_cnt_q  <= '0;
                end else if (i_idx[g].resp_seen || idx_tmo) begin
                    idx_wait_q <= 1'b0;
                end else if (idx_wait_q) begin
                    idx_cnt_q <= idx_cnt_q + 16'h0001;
                end
            end

            always_ff @(posedge i_ref_clk) begin
                if (i_reset) begin
                    uart_wait_q <= 1'b0;
                    uart_cnt_q  <= '0;
                end else if (i_uart[g].pkt_sent) begin
                    uart_wait_q <= 1'b1;
                    uart_cnt_q  <= '0;
                end else if (i_uart[g].resp_seen || uart_tmo) begin
                    uart_wait_q <= 1'b0;
                end else if (uart_wait_q) begin
                    uart_cnt_q <= uart_cnt_q + 16'h0001;
                end
            end

            logic af_prev_q;
            logic ae_prev_q;
            logic q3_prev_q;
            logic q1_prev_q;
            always_ff @(posedge i_ref_clk) begin
                if (i_reset) begin
                    af_prev_q <= 1'b0;
                    ae_prev_q <= 1'b1;
                    q3_prev_q <= 1'b0;
                    q1_prev_q <= 1'b1;
                end else begin
                    af_prev_q <= i_uart[g].almost_full;
                    ae_prev_q <= i_uart[g].almost_empty;
                    q3_prev_q <= i_resp[g].ge_3q;
                    q1_prev_q <= i_resp[g].le_1q;
                end
            end

            localparam int CB = g * siods_pkg::CH_STRIDE;
            localparam int UB = g * siods_pkg::UART_STRIDE;
            localparam int RB = g * siods_pkg::RESP_STRIDE;
            assign ev_set[CB + siods_pkg::EV_IDX_DATA]  = i_idx[g].rx_done;
            assign ev_set[CB + siods_pkg::EV_IDX_FRAME] = i_idx[g].rx_done
                                                          & ~i_idx[g].rx_stop;
            assign ev_set[CB + siods_pkg::EV_IDX_TMO]   = idx_tmo;
            assign ev_set[CB + siods_pkg::EV_UART_TMO]  = uart_tmo;
            assign ev_set[UB + siods_pkg::EV_UART_AE]   = i_uart[g].almost_empty
                                                          & ~ae_prev_q;
            assign ev_set[UB + siods_pkg::EV_UART_AF]   = i_uart[g].almost_full
                                                          & ~af_prev_q;
            assign ev_set[RB + siods_pkg::EV_RESP_1Q]   = i_resp[g].le_1q
                                                          & ~q1_prev_q;
            assign ev_set[RB + siods_pkg::EV_RESP_3Q]   = i_resp[g].ge_3q
                                                          & ~q3_prev_q;
        end
    endgenerate

    // Latched events; a new event wins over a clear in the same cycle.
    assign ev_clr = (i_wr && i_addr == siods_pkg::OFS_EVENTS) ? i_wdata[15:0] : 16'h0000;

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            events_q <= siods_pkg::RST_EVENT;
        end else begin
            events_q <= (events_q & ~ev_clr) | ev_set;
        end
    end

    // Summary status and the open-drain interrupt request.
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_int_status <= 1'b0;
            o_inta_n     <= 1'b1;
            o_inta_oe_n  <= 1'b1;
        end else begin
            o_int_status <= |(events_q & i_int_enable);
            o_inta_n     <= 1'b0;
            o_inta_oe_n  <= ~(i_master_int_en & |(events_q & i_int_enable));
        end
    end

    // Termination fan-out with index auto-termination override.
    always_comb begin
        for (int p = 0; p < siods_pkg::PAIRS; p++) begin
            if (p < siods_pkg::TERM_SGL) begin
                term_d[p] = term_q[p];
            end else begin
                term_d[p] = term_q[siods_pkg::TERM_SGL
                                   + (p - siods_pkg::TERM_SGL) / siods_pkg::TERM_GRP];
            end
        end
        if (i_idx[0].auto_term) begin
            term_d[siods_pkg::IDX1_PAIR] = ~i_idx[0].transmitting;
        end
        if (i_idx[1].auto_term) begin
            term_d[siods_pkg::IDX2_PAIR] = ~i_idx[1].transmitting;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_term_en <= 32'h0000_0000;
        end else begin
            o_term_en <= term_d;
        end
    end
endmodule : siods_regs
`default_nettype wire

/* File: verilog/siods_pkg.sv */
// Package with offsets, field layouts and carriers for the serial I/O register ports.
`default_nettype none
package siods_pkg;
    localparam logic [7:0] OFS_IDX1_IMM    = 8'h20;
    localparam logic [7:0] OFS_IDX1_AUTO_A = 8'h24;
    localparam logic [7:0] OFS_IDX1_AUTO_B = 8'h28;
    localparam logic [7:0] OFS_IDX2_IMM    = 8'h2c;
    localparam logic [7:0] OFS_IDX2_AUTO_A = 8'h30;
    localparam logic [7:0] OFS_IDX2_AUTO_B = 8'h34;
    localparam logic [7:0] OFS_UART1_FIFO  = 8'h38;
    localparam logic [7:0] OFS_UART2_FIFO  = 8'h3c;
    localparam logic [7:0] OFS_TERM        = 8'h40;
    localparam logic [7:0] OFS_EVENTS      = 8'h44;
    localparam logic [7:0] OFS_UART1_RDACK = 8'h48;
    localparam logic [7:0] OFS_UART2_RDACK = 8'h4c;
    localparam logic [7:0] OFS_RESP1_FIFO  = 8'h50;
    localparam logic [7:0] OFS_RESP2_FIFO  = 8'h54;

    localparam int WORD_W   = 9;
    localparam int STAT_W   = 3;
    localparam int TERM_W   = 14;
    localparam int TERM_SGL = 8;
    localparam int TERM_GRP = 4;
    localparam int PAIRS    = 32;
    localparam int EVENT_W  = 16;
    localparam int TMO_W    = 16;

    // Event bit positions; per-channel bits sit at CH_STRIDE (index and timeout bits), UART_STRIDE or RESP_STRIDE times the channel.
    localparam int EV_IDX_DATA  = 0;
    localparam int EV_IDX_FRAME = 1;
    localparam int EV_IDX_TMO   = 2;
    localparam int EV_UART_TMO  = 3;
    localparam int CH_STRIDE    = 4;
    localparam int EV_UART_AE   = 8;
    localparam int EV_UART_AF   = 9;
    localparam int UART_STRIDE  = 2;
    localparam int EV_RESP_1Q   = 12;
    localparam int EV_RESP_3Q   = 13;
    localparam int RESP_STRIDE  = 2;

    // Index lines sit on I/O pairs 3 and 5.
    localparam int IDX1_PAIR = 3;
    localparam int IDX2_PAIR = 5;

    localparam logic [31:0] RST_WORD  = 32'h0000_0000;
    localparam logic [13:0] RST_TERM  = 14'h0000;
    localparam logic [15:0] RST_EVENT = 16'h0000;

    localparam int CLK_HZ        = 20_000_000;
    localparam int UART_TMO_US   = 1000;
    localparam int UART_TMO_CYC  = (CLK_HZ / 1_000_000) * UART_TMO_US;

    // Per index interface: configuration levels and receiver/transmitter events.
    typedef struct packed {
        logic               enable;
        logic               tx_first;
        logic               resp12;
        logic               auto_term;
        logic               transmitting;
        logic [STAT_W-1:0]  status;
        logic               rx_done;
        logic               rx_stop;
        logic [WORD_W-1:0]  rx_word;
        logic               sent;
        logic               resp_seen;
        logic [TMO_W-1:0]   timeout_cyc;
    } siods_idx_in_t;

    // Per UART: mode levels, FIFO level flags and packet events.
    typedef struct packed {
        logic        controller;
        logic        loop_test;
        logic        almost_full;
        logic        almost_empty;
        logic        pkt_sent;
        logic        resp_seen;
        logic [31:0] rx_data;
    } siods_uart_in_t;

    // Per response FIFO: head byte and fill flags.
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        logic       ge_3q;
        logic       le_1q;
    } siods_resp_in_t;
endpackage : siods_pkg
`default_nettype wire

/* File: verif/siods_regs_asserts.sv */
// Checker of host port timing and event gating for the serial I/O block.
`default_nettype none
module siods_regs_asserts #(
    parameter int P_UART_TMO_CYC = 20
) (
    input wire logic                              i_ref_clk, i_reset, i_wr, i_rd,
    input wire logic [7:0]                        i_addr,
    input wire logic [31:0]                       i_wdata, o_rdata, o_uart_wdata,
    input wire logic                              o_rvalid, o_int_status, o_inta_n, o_inta_oe_n,
    input wire siods_pkg::siods_idx_in_t [1:0]    i_idx,
    input wire siods_pkg::siods_uart_in_t [1:0]   i_uart,
    input wire siods_pkg::siods_resp_in_t [1:0]   i_resp,
    input wire logic [1:0]                        o_idx_tx_load, o_uart_push, o_resp_pop,
    input wire logic [1:0][8:0]                   o_idx_tx_word,
    input wire logic [1:0][31:0]                  o_read_ack_data
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);
    chk_read_strobe: assert property (i_rd |=> o_rvalid)
        else $error("read gave no valid pulse");
    chk_idle_zero: assert property (!o_rvalid |-> o_rdata == 32'h0)
        else $error("read data not zero when idle");
    chk_tx_load: assert property (i_wr && i_addr == 8'h20 && i_idx[0].enable
        && i_idx[0].tx_first |=> o_idx_tx_load[0] && o_idx_tx_word[0] == $past(i_wdata[8:0]))
        else $error("immediate write did not load");
    chk_uart_push: assert property (i_wr && i_addr == 8'h38 && i_uart[0].controller
        |=> o_uart_push[0] && o_uart_wdata == $past(i_wdata))
        else $error("controller write did not push");
    chk_push_refused: assert property (i_wr && i_addr == 8'h38 && !i_uart[0].controller
        && !i_uart[0].loop_test |=> !o_uart_push[0])
        else $error("push without permission");
    chk_resp_pop: assert property (i_rd && i_addr == 8'h50 && i_resp[0].valid
        |=> o_resp_pop[0] && o_rdata == {24'h0, $past(i_resp[0].data)})
        else $error("response read did not pop");
    chk_empty_resp: assert property (i_rd && i_addr == 8'h50 && !i_resp[0].valid
        |=> !o_resp_pop[0] && o_rdata == 32'h0)
        else $error("empty response read popped");
    chk_rdack_hold: assert property (i_wr && i_addr == 8'h48
        |=> o_read_ack_data[0] == $past(i_wdata))
        else $error("read-ack data not updated");
    chk_inta_gate: assert property (!o_inta_oe_n |-> o_int_status)
        else $error("request without summary status");
    chk_inta_level: assert property (!$past(i_reset) |-> !o_inta_n)
        else $error("request level not low");
endmodule : siods_regs_asserts
bind siods_regs siods_regs_asserts #(.P_UART_TMO_CYC(P_UART_TMO_CYC)) u_chk (.*);
`default_nettype wire

/* File: verif/siods_far_end.sv */
// Far-side model of the response FIFOs behind the host read ports.
`default_nettype none
module siods_far_end #(
    parameter int DEPTH = 8
) (
    input  wire logic                             i_ref_clk,
    input  wire logic [1:0]                       i_pop,
    output var  siods_pkg::siods_resp_in_t [1:0]  o_resp
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] q[2][$];
    task automatic load(input int ch, input logic [7:0] b);
        q[ch].push_back(b);
    endtask : load
    always @(posedge i_ref_clk) begin
        for (int c = 0; c < 2; c++) if (i_pop[c] && q[c].size() > 0) void'(q[c].pop_front());
    end
    initial begin
        o_resp = '0;
        forever begin
            @(negedge i_ref_clk);
            for (int c = 0; c < 2; c++) begin
                o_resp[c].valid = q[c].size() != 0;
                o_resp[c].data  = o_resp[c].valid ? q[c][0] : ~o_resp[c].data;
                o_resp[c].ge_3q = q[c].size() >= DEPTH * 3 / 4;
                o_resp[c].le_1q = q[c].size() <= DEPTH / 4;
            end
        end
    end
endmodule : siods_far_end
`default_nettype wire

/* File: verif/siods_regs_tb.sv */
// Self-checking testbench of the serial I/O register ports.
`default_nettype none
module siods_regs_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_ref_clk = 0, i_reset = 1, i_wr = 0, i_rd = 0, i_master_int_en = 0;
    logic o_rvalid, o_int_status, o_inta_n, o_inta_oe_n;
    logic [7:0] i_addr = '0;
    logic [7:0] b[7];
    logic [7:0] ra[6] = '{8'h24, 8'h28, 8'h30, 8'h34, 8'h48, 8'h4c};
    logic [15:0] i_int_enable = '0;
    logic [31:0] i_wdata = '0, o_rdata, o_uart_wdata, o_term_en, d, e;
    logic [1:0] o_idx_tx_load, o_uart_push, o_uart_pop, o_resp_pop;
    logic [1:0][8:0] o_idx_tx_word, o_idx_auto_a, o_idx_auto_b;
    logic [1:0][31:0] o_read_ack_data;
    siods_pkg::siods_idx_in_t [1:0] i_idx = '0;
    siods_pkg::siods_uart_in_t [1:0] i_uart = '0;
    siods_pkg::siods_resp_in_t [1:0] i_resp;
    int bad_count = 0, check_count = 0;
    siods_regs #(.P_UART_TMO_CYC(20)) u_dut (.*);
    siods_far_end u_far (.i_ref_clk(i_ref_clk), .i_pop(o_resp_pop), .o_resp(i_resp));
    initial forever #25 i_ref_clk = ~i_ref_clk;
    task automatic cyc(input int n);
        repeat (n) @(posedge i_ref_clk);
        #2;
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        cyc(1);
        {i_wr, i_addr, i_wdata} = {1'b1, a, v};
        cyc(1);
        i_wr = 0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        cyc(1);
        {i_rd, i_addr} = {1'b1, a};
        cyc(1);
        i_rd = 0;
        v = o_rdata;
    endtask : rd
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        check_count++;
        if (g !== x) begin
            bad_count++;
            $display("[FAIL] %0t got %h want %h", $time, g, x);
        end
    endtask : chk
    function automatic logic [31:0] term_map(input logic [13:0] t);
        term_map = {24'h0, t[7:0]};
        for (int k = 8; k < 14; k++) term_map[8 + 4 * (k - 8) +: 4] = {4{t[k]}};
    endfunction : term_map
    task automatic wrap_up();
        if (bad_count == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : wrap_up
    initial begin
        void'($urandom(19968));
        cyc(4);
        i_reset = 0;
        rd(8'h44, d);
        chk(d, 32'h0);
        chk(32'(o_inta_oe_n), 32'h1);
        foreach (ra[i]) begin
            e = $urandom();
            wr(ra[i], e);
            rd(ra[i], d);
            chk(d, i < 4 ? e & 32'h1ff : e);
            if (i < 4) begin
                chk(32'(i[0] ? o_idx_auto_b[i[1]] : o_idx_auto_a[i[1]]), e & 32'h1ff);
            end
        end
        rd(8'h58, d);
        chk(d, 32'h0);
        e = $urandom();
        wr(8'h40, e);
        cyc(1);
        chk(o_term_en, term_map(e[13:0]));
        {i_idx[0].auto_term, i_idx[0].transmitting} = 2'b11;
        cyc(3);
        chk(o_term_en, term_map(e[13:0]) & ~32'h8);
        i_idx[0].transmitting = 0;
        cyc(3);
        chk(o_term_en, term_map(e[13:0]) | 32'h8);
        {i_idx[0].enable, i_idx[0].tx_first} = 2'b11;
        wr(8'h20, e);
        chk(32'(o_idx_tx_load), 32'h1);
        {i_int_enable, i_master_int_en, i_idx[0].resp12} = {16'h1, 1'b1, 1'b1};
        i_idx[0].status = 3'($urandom());
        i_idx[0].rx_word = 9'($urandom());
        {i_idx[1].status, i_idx[1].rx_word} = 12'($urandom()) | 12'he00;
        {i_idx[0].rx_done, i_idx[1].rx_done, i_idx[1].rx_stop} = 3'b111;
        cyc(1);
        {i_idx[0].rx_done, i_idx[1].rx_done} = 2'b00;
        cyc(3);
        chk(32'({o_int_status, o_inta_oe_n}), 32'h2);
        rd(8'h20, d);
        chk(d, {20'h0, i_idx[0].status, i_idx[0].rx_word});
        rd(8'h2c, d);
        chk(d, {23'h0, i_idx[1].rx_word});
        i_master_int_en = 0;
        cyc(3);
        chk(32'({o_int_status, o_inta_oe_n}), 32'h3);
        rd(8'h44, d);
        chk(d, 32'h13);
        wr(8'h44, 32'h1);
        rd(8'h44, d);
        chk(d, 32'h12);
        i_uart[0].controller = 1;
        wr(8'h38, e);
        chk({30'h0, o_uart_push}, 32'h1);
        i_uart[0] = {2'b00, 4'h0, 32'($urandom())};
        rd(8'h38, d);
        chk(d, i_uart[0].rx_data);
        chk({30'h0, o_uart_pop}, 32'h1);
        i_uart[0].loop_test = 1;
        wr(8'h38, e);
        chk({30'h0, o_uart_push}, 32'h1);
        wr(8'h44, 32'hffff_ffff);
        i_idx[0].timeout_cyc = 16'h0005;
        {i_uart[1].pkt_sent, i_idx[0].sent} = 2'b11;
        cyc(1);
        {i_uart[1].pkt_sent, i_idx[0].sent} = 2'b00;
        cyc(10);
        rd(8'h44, d);
        chk(d, 32'h4);
        cyc(10);
        rd(8'h44, d);
        chk(d, 32'h84);
        wr(8'h44, 32'hffff_ffff);
        foreach (b[i]) b[i] = 8'($urandom());
        foreach (b[i]) u_far.load(0, b[i]);
        {i_uart[0].almost_full, i_uart[1].almost_empty} = 2'b11;
        cyc(3);
        rd(8'h44, d);
        chk(d, 32'h2600);
        foreach (b[i]) begin
            rd(8'h50, d);
            chk(d, {24'h0, b[i]});
        end
        rd(8'h50, d);
        chk(d, 32'h0);
        rd(8'h44, d);
        chk(d, 32'h3600);
        wrap_up();
    end
    initial begin
        repeat (2000) @(posedge i_ref_clk);
        bad_count++;
        wrap_up();
    end
endmodule : siods_regs_tb
`default_nettype wire
